// *** hw/csp_cfg.svh ***
// register offsets, bit positions, reset values and limits of the core status block
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

// ----------------------------------------------------------------------------
// special function register offsets
// ----------------------------------------------------------------------------
`define CSP_ADDR_SPL    8'h81
`define CSP_ADDR_DPL    8'h82
`define CSP_ADDR_DPH    8'h83
`define CSP_ADDR_POWER_CONTROL   8'h87
`define CSP_ADDR_SPH    8'hB7
`define CSP_ADDR_STACK_BOUNDARY_CONTROL  8'hBF
`define CSP_ADDR_PSW    8'hD0
`define CSP_BIT_PSW_BASE 5'h1A

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CSP_PSW_CY      7
`define CSP_PSW_AC      6
`define CSP_PSW_F0      5
`define CSP_PSW_RS_HI   4
`define CSP_PSW_RS_LO   3
`define CSP_PSW_OV      2
`define CSP_PSW_F1      1
`define CSP_PSW_PAR     0
`define CSP_POWER_CONTROL_BAUD   7
`define CSP_SPH_ORG_HI  5
`define CSP_SPH_ORG_LO  3
`define CSP_SPH_SP_HI   2
`define CSP_ST_WL_HI    7
`define CSP_ST_WL_LO    3
`define CSP_ST_RST_SEL  2
`define CSP_ST_ENABLE   1
`define CSP_ST_FLAG     0

// ----------------------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------------------
`define CSP_RST_PSW     8'h00
`define CSP_RST_POWER_CONTROL    8'h00
`define CSP_RST_DPL     8'h00
`define CSP_RST_DPH     8'h00
`define CSP_RST_SPL     8'h00
`define CSP_RST_SPH     8'h09
`define CSP_RST_STACK_BOUNDARY_CONTROL   8'h00
`define CSP_MASK_SPH    8'h3F
`define CSP_MASK_PSW    8'hFE
`define CSP_STACK_TOP   11'h7FF
`define CSP_BANK_BYTES  3

`endif

// *** hw/csp_pkg.sv ***
// types and shared functions of the core status, pointer and stack registers
`include "csp_cfg.svh"
package csp_pkg;

  typedef enum logic [2:0] {
    CSP_OP_NONE = 3'b000,
    CSP_OP_ADD  = 3'b001,
    CSP_OP_ADDC = 3'b010,
    CSP_OP_SUBB = 3'b011,
    CSP_OP_MUL  = 3'b100,
    CSP_OP_DIV  = 3'b101
  } csp_alu_op_t;

  typedef struct packed {
    logic [7:0]  program_status_word;
    logic [7:0]  power_control;
    logic [7:0]  data_pointer_low;
    logic [7:0]  data_pointer_high;
    logic [7:0]  spl;
    logic [7:0]  stack_pointer_high;
    logic [7:0]  stack_boundary_control;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        rhit;
    logic        stk_irq;
    logic        stk_rst;
    logic        stk_wr;
    logic        stk_rd;
    logic [10:0] stk_addr;
  } csp_state_t;

  // even parity over the accumulator plus this bit
  function automatic logic csp_parity(input logic [7:0] v);
    return ^v;
  endfunction

  function automatic logic csp_is_bank(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

endpackage

// *** hw/csp_unit_if.sv ***
// signals between the register top and its flag and stack helpers
`timescale 1ns/100ps
`default_nettype none
interface csp_unit_if;
  import csp_pkg::*;
  csp_alu_op_t op;
  logic        cy;
  logic        ac;
  logic        ov;
  logic [7:0]  psw_cur;
  logic [7:0]  psw_arith;
  logic [10:0] sp_cur;
  logic [2:0]  origin;
  logic [4:0]  waterline;
  logic        guard_en;
  logic        push;
  logic        pop;
  logic [10:0] sp_next;
  logic        move;
  logic        level_hit;
  logic        violation;

  modport top_flag  (output op, cy, ac, ov, psw_cur, input psw_arith);
  modport flag      (input op, cy, ac, ov, psw_cur, output psw_arith);
  modport top_stack (output sp_cur, origin, waterline, guard_en, push, pop,
                     input sp_next, move, level_hit, violation);
  modport stack     (input sp_cur, origin, waterline, guard_en, push, pop,
                     output sp_next, move, level_hit, violation);
endinterface
`default_nettype wire

// *** hw/csp_flag_unit.sv ***
// arithmetic flag update of the program status word
`timescale 1ns/100ps
`default_nettype none
module csp_flag_unit
  import csp_pkg::*;
(
  csp_unit_if.flag u
);

  always_comb begin
    u.psw_arith = u.psw_cur;
    case (u.op)
      CSP_OP_ADD, CSP_OP_ADDC: begin
        u.psw_arith[`CSP_PSW_CY] = u.cy;
        u.psw_arith[`CSP_PSW_AC] = u.ac;
        u.psw_arith[`CSP_PSW_OV] = u.ov;
      end
      CSP_OP_SUBB, CSP_OP_MUL, CSP_OP_DIV: begin
        u.psw_arith[`CSP_PSW_CY] = u.cy;
        u.psw_arith[`CSP_PSW_OV] = u.ov;
      end
      default: begin
        u.psw_arith = u.psw_cur;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** hw/csp_stack_unit.sv ***
// stack pointer step, waterline compare and boundary check
`timescale 1ns/100ps
`default_nettype none
module csp_stack_unit
  import csp_pkg::*;
(
  csp_unit_if.stack u
);

  logic [10:0] base;
  logic [10:0] level_next;
  logic        over;
  logic        under;

  always_comb begin
    base  = {u.origin, 8'h00};
    over  = u.push && (u.sp_cur == `CSP_STACK_TOP);
    under = u.pop && (u.sp_cur == base);
    u.violation = u.guard_en && (over || under);
    u.move      = (u.push || u.pop) && !u.violation;
    u.sp_next   = u.push ? u.sp_cur + 11'h001 : u.sp_cur - 11'h001;
    level_next  = u.sp_next - base;
    u.level_hit = u.push && u.move && (level_next > {3'h0, u.waterline, 3'h0});
  end

endmodule
`default_nettype wire

// *** hw/cpu_status_pointer_stack_regs.sv ***
// core status word, power control, data pointer, stack pointer and stack guard registers
//
// Functional notes
// - carry bit 7 follows add, add-with-carry, subtract, multiply, divide.
// - auxiliary carry bit 6 follows add and add-with-carry only.
// - status bits 5 and 1 are user flags, untouched by arithmetic.
// - overflow bit 2 follows add, add-with-carry, subtract, multiply, divide.
// - status bit 0 keeps accumulator plus parity bit even.
// - power control bit 7 doubles serial baud rate, resets low.
// - pointer low byte holds pointer bits 7:0, resets low.
// - pointer high byte holds pointer upper byte, resets low.
// - 16-bit pointer is high byte over low byte.
// - stack low register holds stack address bits 7:0, resets low.
// - stack high bits 2:0 hold stack address 10:8, reset 001.
// - stack high bits 5:3 hold stack origin 10:8, reset 001.
// - guard register bits 7:3 hold waterline setting, reset low.
// - violation raises interrupt if guard bit 2 low, reset if high.
// - guard bit 1 enables boundary checking, resets low.
// - guard bit 0 is the waterline flag, resets low.
// - push increments then writes; pop reads then decrements.
// - four eight-register banks occupy the first 32 data bytes.
`timescale 1ns/100ps
`default_nettype none
module cpu_status_pointer_stack_regs
  import csp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_rvalid,
  output logic             sfr_rhit,
  input  wire logic        bit_wr,
  input  wire logic [7:0]  bit_addr,
  input  wire logic        bit_wdata,
  input  wire logic [7:0]  acc,
  input  wire csp_alu_op_t alu_op,
  input  wire logic        alu_cy,
  input  wire logic        alu_ac,
  input  wire logic        alu_ov,
  input  wire logic        data_pointer_word_load,
  input  wire logic        data_pointer_word_inc,
  input  wire logic [15:0] data_pointer_word_wdata,
  output logic      [15:0] data_pointer_bits,
  input  wire logic        push,
  input  wire logic        pop,
  output logic      [10:0] stack_addr,
  output logic             stack_wr,
  output logic             stack_rd,
  input  wire logic [2:0]  reg_index,
  output logic      [4:0]  reg_addr,
  output logic      [1:0]  bank_sel,
  output logic             baud_doubler,
  output logic             stack_irq,
  output logic             stack_rst
);

  csp_state_t  s_q;
  csp_state_t  s_d;
  csp_unit_if  u ();
  logic [15:0] dp_inc;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  csp_flag_unit  flag_i  (.u (u.flag));
  csp_stack_unit stack_i (.u (u.stack));

  assign u.op        = alu_op;
  assign u.cy        = alu_cy;
  assign u.ac        = alu_ac;
  assign u.ov        = alu_ov;
  assign u.psw_cur   = s_q.program_status_word;
  assign u.sp_cur    = {s_q.stack_pointer_high[`CSP_SPH_SP_HI:0], s_q.spl};
  assign u.origin    = s_q.stack_pointer_high[`CSP_SPH_ORG_HI:`CSP_SPH_ORG_LO];
  assign u.waterline = s_q.stack_boundary_control[`CSP_ST_WL_HI:`CSP_ST_WL_LO];
  assign u.guard_en  = s_q.stack_boundary_control[`CSP_ST_ENABLE];
  assign u.push      = push;
  assign u.pop       = pop && !push;
  assign dp_inc      = {s_q.data_pointer_high, s_q.data_pointer_low} + 16'h0001;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.rvalid  = 1'b0;
    s_d.rhit    = 1'b0;
    s_d.stk_irq = 1'b0;
    s_d.stk_rst = 1'b0;
    s_d.stk_wr  = 1'b0;
    s_d.stk_rd  = 1'b0;

    // arithmetic flags first; a direct write to the status word overrides them
    s_d.program_status_word = u.psw_arith;

    // data pointer as a 16-bit unit
    if (data_pointer_word_load) begin
      {s_d.data_pointer_high, s_d.data_pointer_low} = data_pointer_word_wdata;
    end else if (data_pointer_word_inc) begin
      {s_d.data_pointer_high, s_d.data_pointer_low} = dp_inc;
    end

    // stack movement
    if (u.move) begin
      s_d.spl                     = u.sp_next[7:0];
      s_d.stack_pointer_high[`CSP_SPH_SP_HI:0]   = u.sp_next[10:8];
      // push writes at the incremented top, pop reads the old top
      s_d.stk_addr = push ? u.sp_next : u.sp_cur;
      s_d.stk_wr   = push;
      s_d.stk_rd   = !push;
    end
    if (u.violation) begin
      s_d.stk_irq = !s_q.stack_boundary_control[`CSP_ST_RST_SEL];
      s_d.stk_rst = s_q.stack_boundary_control[`CSP_ST_RST_SEL];
    end

    // direct byte writes
    if (sfr_wr) begin
      if (csp_is_bank(sfr_addr, `CSP_ADDR_PSW)) begin
        // user flags and bank select take software's value
        s_d.program_status_word = sfr_wdata & `CSP_MASK_PSW;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_POWER_CONTROL)) begin
        s_d.power_control = sfr_wdata;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_DPL)) begin
        s_d.data_pointer_low = sfr_wdata;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_DPH)) begin
        s_d.data_pointer_high = sfr_wdata;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_SPL)) begin
        s_d.spl = sfr_wdata;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_SPH)) begin
        s_d.stack_pointer_high = sfr_wdata & `CSP_MASK_SPH;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_STACK_BOUNDARY_CONTROL)) begin
        // flag can only be cleared by software
        s_d.stack_boundary_control[7:1] = sfr_wdata[7:1];
        s_d.stack_boundary_control[`CSP_ST_FLAG] = s_q.stack_boundary_control[`CSP_ST_FLAG] & sfr_wdata[`CSP_ST_FLAG];
      end
    end

    // bit-addressed writes to the status word
    if (bit_wr && (bit_addr[7:3] == `CSP_BIT_PSW_BASE)) begin
      s_d.program_status_word[bit_addr[2:0]] = bit_wdata;
    end

    // waterline crossing beats a software clear in the same cycle
    if (u.level_hit) begin
      s_d.stack_boundary_control[`CSP_ST_FLAG] = 1'b1;
    end

    // parity is always recomputed from the accumulator
    s_d.program_status_word[`CSP_PSW_PAR] = csp_parity(acc);

    // registered read data
    if (sfr_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rhit   = 1'b1;
      if (csp_is_bank(sfr_addr, `CSP_ADDR_PSW)) begin
        s_d.rdata = {s_q.program_status_word[7:1], csp_parity(acc)};
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_POWER_CONTROL)) begin
        s_d.rdata = s_q.power_control;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_DPL)) begin
        s_d.rdata = s_q.data_pointer_low;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_DPH)) begin
        s_d.rdata = s_q.data_pointer_high;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_SPL)) begin
        s_d.rdata = s_q.spl;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_SPH)) begin
        s_d.rdata = s_q.stack_pointer_high;
      end else if (csp_is_bank(sfr_addr, `CSP_ADDR_STACK_BOUNDARY_CONTROL)) begin
        s_d.rdata = s_q.stack_boundary_control;
      end else begin
        s_d.rdata = 8'h00;
        s_d.rhit  = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.program_status_word      <= `CSP_RST_PSW;
      s_q.power_control     <= `CSP_RST_POWER_CONTROL;
      s_q.data_pointer_low      <= `CSP_RST_DPL;
      s_q.data_pointer_high      <= `CSP_RST_DPH;
      s_q.spl      <= `CSP_RST_SPL;
      s_q.stack_pointer_high      <= `CSP_RST_SPH;
      s_q.stack_boundary_control    <= `CSP_RST_STACK_BOUNDARY_CONTROL;
      s_q.stk_addr <= 11'h000;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign sfr_rdata         = s_q.rdata;
  assign sfr_rvalid        = s_q.rvalid;
  assign sfr_rhit          = s_q.rhit;
  assign data_pointer_bits = {s_q.data_pointer_high, s_q.data_pointer_low};
  assign stack_addr        = s_q.stk_addr;
  assign stack_wr          = s_q.stk_wr;
  assign stack_rd          = s_q.stk_rd;
  assign stack_irq         = s_q.stk_irq;
  assign stack_rst         = s_q.stk_rst;
  assign baud_doubler      = s_q.power_control[`CSP_POWER_CONTROL_BAUD];
  assign bank_sel          = s_q.program_status_word[`CSP_PSW_RS_HI:`CSP_PSW_RS_LO];
  assign reg_addr          = {bank_sel, reg_index};
  // stack level flag is bit 0 of the guard register, read back above

endmodule
`default_nettype wire

// *** testbench/csp_regs_properties.sv ***
// port-level assertions for the core status, pointer and stack registers
`timescale 1ns/100ps
`default_nettype none
`include "csp_cfg.svh"
module csp_regs_properties (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_rvalid,
  input wire logic        bit_wr,
  input wire logic        data_pointer_word_load,
  input wire logic        data_pointer_word_inc,
  input wire logic [15:0] data_pointer_word_wdata,
  input wire logic [15:0] data_pointer_bits,
  input wire logic        push,
  input wire logic        pop,
  input wire logic        stack_wr,
  input wire logic        stack_rd,
  input wire logic [2:0]  reg_index,
  input wire logic [4:0]  reg_addr,
  input wire logic [1:0]  bank_sel,
  input wire logic        baud_doubler,
  input wire logic        stack_irq,
  input wire logic        stack_rst
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_rd_answer: assert property (sfr_rd |=> sfr_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (sfr_rvalid |-> $past(sfr_rd))
    else $error("read answer without request");
  a_bank_addr: assert property (reg_addr == {bank_sel, reg_index})
    else $error("register address not in selected bank");
  a_bank_write: assert property (sfr_wr && sfr_addr == `CSP_ADDR_PSW && !bit_wr
    |=> bank_sel == $past(sfr_wdata[4:3])) else $error("bank select not written");
  a_baud_write: assert property (sfr_wr && sfr_addr == `CSP_ADDR_POWER_CONTROL
    |=> baud_doubler == $past(sfr_wdata[7])) else $error("baud doubler not written");
  a_ptr_load: assert property (data_pointer_word_load && !sfr_wr
    |=> data_pointer_bits == $past(data_pointer_word_wdata)) else $error("pointer load lost");
  a_ptr_step: assert property (data_pointer_word_inc && !data_pointer_word_load && !sfr_wr
    |=> data_pointer_bits == $past(data_pointer_bits) + 16'h0001)
    else $error("pointer increment wrong");
  a_high_write: assert property (sfr_wr && sfr_addr == `CSP_ADDR_DPH && !data_pointer_word_load
    && !data_pointer_word_inc |=> data_pointer_bits[15:8] == $past(sfr_wdata))
    else $error("pointer high byte not written");
  a_push_answer: assert property (push |-> ##[1:2] (stack_wr || stack_irq || stack_rst))
    else $error("push not answered");
  a_pop_answer: assert property (pop && !push |-> ##[1:2] (stack_rd || stack_irq || stack_rst))
    else $error("pop not answered");
  a_strobe_cause: assert property (stack_wr |-> $past(push) && !stack_rd)
    else $error("stack write without push");
  a_one_action: assert property (!(stack_irq && stack_rst))
    else $error("interrupt and reset together");
  a_guard_cause: assert property ((stack_irq || stack_rst)
    |-> $past(push) || $past(pop) || $past(push, 2) || $past(pop, 2))
    else $error("violation without stack move");
endmodule

bind cpu_status_pointer_stack_regs csp_regs_properties chk_u (.sys_clk, .resetn, .sfr_addr,
  .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rvalid, .bit_wr, .data_pointer_word_load, .data_pointer_word_inc, .data_pointer_word_wdata,
  .data_pointer_bits, .push, .pop, .stack_wr, .stack_rd, .reg_index, .reg_addr, .bank_sel,
  .baud_doubler, .stack_irq, .stack_rst);
`default_nettype wire

// *** testbench/csp_core_model.sv ***
// stack memory side of the execution core, fed by the stack strobes
`timescale 1ns/100ps
`default_nettype none
module csp_core_model (
  input wire logic        sys_clk,
  input wire logic [10:0] stack_addr,
  input wire logic        stack_wr,
  input wire logic        stack_rd,
  input wire logic [7:0]  push_data,
  output logic      [7:0] pop_data
);
  logic [7:0] mem [0:2047];

  always @(posedge sys_clk) begin
    if (stack_wr) begin
      mem[stack_addr] <= push_data;
    end
    if (stack_rd) begin
      pop_data <= mem[stack_addr];
    end else begin
      pop_data <= ~pop_data;
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_cpu_status_pointer_stack_regs.sv ***
// self-checking bench for the core status, pointer and stack registers
`timescale 1ns/100ps
`default_nettype none
`include "csp_cfg.svh"
module tb_cpu_status_pointer_stack_regs;
  import csp_pkg::*;
  logic        sys_clk, resetn, sfr_wr, sfr_rd, sfr_rvalid, sfr_rhit, bit_wr, bit_wdata;
  logic        alu_cy, alu_ac, alu_ov, data_pointer_word_load, data_pointer_word_inc, push, pop, stack_wr, stack_rd;
  logic        baud_doubler, stack_irq, stack_rst;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, bit_addr, acc, push_data, pop_data;
  logic [15:0] data_pointer_word_wdata, data_pointer_bits;
  logic [10:0] stack_addr;
  logic [4:0]  reg_addr;
  logic [2:0]  reg_index;
  logic [1:0]  bank_sel;
  logic [3:0]  s;
  csp_alu_op_t alu_op;
  int          err_total = 0;
  int          n_checks = 0;
  int          cycles = 0;

  cpu_status_pointer_stack_regs dut_u (.*);
  csp_core_model partner_u (.sys_clk, .stack_addr, .stack_wr, .stack_rd, .push_data, .pop_data);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop;
    end
  end

  task automatic cyc;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc;
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    cyc;
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc;
    sfr_rd = 1'b0;
    ck(16'({sfr_rvalid, sfr_rhit}), 16'({1'b1, h}));
    ck(16'(sfr_rdata), 16'(e));
  endtask

  // one stack request; strobes sampled at once, guard pulses over two cycles
  task automatic stk(input logic p, input logic q);
    cyc;
    push = p;
    pop = q;
    cyc;
    push = 1'b0;
    pop = 1'b0;
    s = {stack_wr, stack_rd, stack_irq, stack_rst};
    cyc;
    s[1:0] = s[1:0] | {stack_irq, stack_rst};
  endtask

  task automatic t_reset;
    logic [7:0] a [8] = '{`CSP_ADDR_PSW, `CSP_ADDR_POWER_CONTROL, `CSP_ADDR_DPL, `CSP_ADDR_DPH,
                          `CSP_ADDR_SPL, `CSP_ADDR_SPH, `CSP_ADDR_STACK_BOUNDARY_CONTROL, 8'h80};
    logic [7:0] e [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(a[i], e[i], i < 7);
    end
  endtask

  task automatic t_pointer;
    wr(`CSP_ADDR_DPH, 8'h12);
    wr(`CSP_ADDR_DPL, 8'h34);
    ck(data_pointer_bits, 16'h1234);
    cyc;
    data_pointer_word_wdata = 16'hABFF;
    data_pointer_word_load = 1'b1;
    cyc;
    data_pointer_word_load = 1'b0;
    data_pointer_word_inc = 1'b1;
    cyc;
    data_pointer_word_inc = 1'b0;
    ck(data_pointer_bits, 16'hAC00);
    rd(`CSP_ADDR_DPH, 8'hAC, 1'b1);
    rd(`CSP_ADDR_DPL, 8'h00, 1'b1);
  endtask

  task automatic t_status;
    csp_alu_op_t ops [5] = '{CSP_OP_ADD, CSP_OP_SUBB, CSP_OP_ADDC, CSP_OP_MUL, CSP_OP_DIV};
    logic [2:0] f [5] = '{3'h7, 3'h0, 3'h1, 3'h6, 3'h3};
    logic [7:0] x [5] = '{8'hE6, 8'h62, 8'h26, 8'hA2, 8'h26};
    for (int b = 0; b < 4; b++) begin
      wr(`CSP_ADDR_PSW, {3'h0, 2'(b), 3'h0});
      ck(16'(reg_addr), 16'({2'(b), 3'h5}));
    end
    wr(`CSP_ADDR_PSW, 8'hFF);
    rd(`CSP_ADDR_PSW, 8'hFE, 1'b1);
    acc = 8'h07;
    rd(`CSP_ADDR_PSW, 8'hFF, 1'b1);
    acc = 8'h00;
    wr(`CSP_ADDR_PSW, 8'h22);
    for (int i = 0; i < 5; i++) begin
      cyc;
      alu_op = ops[i];
      {alu_cy, alu_ac, alu_ov} = f[i];
      cyc;
      alu_op = CSP_OP_NONE;
      rd(`CSP_ADDR_PSW, x[i], 1'b1);
    end
    cyc;
    bit_addr = 8'hD5;
    bit_wr = 1'b1;
    cyc;
    bit_wr = 1'b0;
    rd(`CSP_ADDR_PSW, 8'h06, 1'b1);
  endtask

  task automatic t_power;
    wr(`CSP_ADDR_POWER_CONTROL, 8'h80);
    ck(16'(baud_doubler), 16'h0001);
    rd(`CSP_ADDR_POWER_CONTROL, 8'h80, 1'b1);
    wr(`CSP_ADDR_POWER_CONTROL, 8'h00);
    ck(16'(baud_doubler), 16'h0000);
  endtask

  task automatic t_stack;
    push_data = 8'h5A;
    stk(1'b1, 1'b0);
    ck(16'({s, stack_addr}), 16'({4'h8, 11'h101}));
    stk(1'b0, 1'b1);
    ck(16'({s, stack_addr}), 16'({4'h4, 11'h101}));
    ck(16'(pop_data), 16'h005A);
    rd(`CSP_ADDR_SPL, 8'h00, 1'b1);
    wr(`CSP_ADDR_STACK_BOUNDARY_CONTROL, 8'h02);
    stk(1'b0, 1'b1);
    ck(16'(s), 16'h0002);
    wr(`CSP_ADDR_STACK_BOUNDARY_CONTROL, 8'h06);
    stk(1'b0, 1'b1);
    ck(16'(s), 16'h0001);
    wr(`CSP_ADDR_STACK_BOUNDARY_CONTROL, 8'h00);
    stk(1'b0, 1'b1);
    ck(16'(s), 16'h0004);
    rd(`CSP_ADDR_SPH, 8'h08, 1'b1);
    wr(`CSP_ADDR_SPH, 8'h09);
    wr(`CSP_ADDR_SPL, 8'h00);
    wr(`CSP_ADDR_STACK_BOUNDARY_CONTROL, 8'h0A);
    repeat (9) stk(1'b1, 1'b0);
    rd(`CSP_ADDR_STACK_BOUNDARY_CONTROL, 8'h0B, 1'b1);
    wr(`CSP_ADDR_STACK_BOUNDARY_CONTROL, 8'h0A);
    rd(`CSP_ADDR_STACK_BOUNDARY_CONTROL, 8'h0A, 1'b1);
  endtask

  // reset pulled in mid-run must bring the data pointer, baud doubler, stack high and guard registers back to their reset values
  task automatic t_rerun;
    wr(`CSP_ADDR_DPH, 8'h55);
    wr(`CSP_ADDR_POWER_CONTROL, 8'h80);
    resetn = 1'b0;
    cyc;
    cyc;
    resetn = 1'b1;
    ck(data_pointer_bits, 16'h0000);
    ck(16'(baud_doubler), 16'h0000);
    rd(`CSP_ADDR_SPH, 8'h09, 1'b1);
    rd(`CSP_ADDR_STACK_BOUNDARY_CONTROL, 8'h00, 1'b1);
  endtask

  initial begin
    {sfr_wr, sfr_rd, bit_wr, bit_wdata, alu_cy, alu_ac, alu_ov} = '0;
    {data_pointer_word_load, data_pointer_word_inc, push, pop, resetn} = '0;
    {sfr_addr, sfr_wdata, bit_addr, acc, push_data} = '0;
    data_pointer_word_wdata = 16'h0000;
    reg_index = 3'h5;
    alu_op = CSP_OP_NONE;
    repeat (5) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    t_reset;
    t_pointer;
    t_status;
    t_power;
    t_stack;
    t_rerun;
    report_and_stop;
  end
endmodule
`default_nettype wire
